// *** hw/standby_resume_pkg.sv ***
package standby_resume_pkg;
    localparam int unsigned HOLD_GROUPS   = 8;
    localparam int unsigned CLK_GROUPS    = 8;
    localparam int unsigned CLK_RATE_HZ   = 20_000_000;
    // Self-test wait period, in microseconds
    localparam int unsigned WAIT_TIME_US  = 100;
    localparam int unsigned WAIT_CYCLES   = (WAIT_TIME_US * (CLK_RATE_HZ / 1_000_000));
    localparam int unsigned CNT_W         = 16;
    localparam int unsigned ACK_DELAY     = 2;
    localparam logic [1:0]  SEL_MEMORY    = 2'h1;
    localparam logic [1:0]  SEL_LOGIC     = 2'h2;
    localparam logic [1:0]  SEL_BOTH      = 2'h3;
    localparam logic [1:0]  SEL_RESET     = 2'h3;
    localparam logic [7:0]  HOLD_RESET    = 8'h00;
    localparam logic [7:0]  STOP_RESET    = 8'h00;
    localparam logic [1:0]  RESULT_RESET  = 2'h0;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_DECIDE= 3'b001,
        ST_WAIT  = 3'b011,
        ST_TEST  = 3'b010,
        ST_DONE  = 3'b110
    } seq_state_t;
endpackage

// *** hw/clock_gate_slice.sv ***
`timescale 1ns/1ps
module clock_gate_slice (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Control
    input  wire logic stop_bit,
    input  wire logic keep_bit,
    input  wire logic chip_standby,
    // Status
    output logic      clk_enable,
    output logic      stop_status
);
    logic next_clk_enable;
    logic next_stop_status;

    always_comb begin
        next_clk_enable  = !stop_bit && (!chip_standby || keep_bit);
        // Outside standby, status drops only once the enable really runs again
        next_stop_status = stop_bit || !clk_enable;
        if (chip_standby) begin
            next_stop_status = stop_bit;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clk_enable  <= 1'b1;
            stop_status <= 1'b0;
        end else begin
            clk_enable  <= next_clk_enable;
            stop_status <= next_stop_status;
        end
    end
endmodule

// *** hw/standby_resume_control.sv ***
`timescale 1ns/1ps
// Behaviour
// - Always-on pins keep state, never held
// - Deepest sleep entry holds switchable pins
// - Held buffer ignores peripheral and pin
// - Writing zero to group bit releases
// - Power-on test runs both domains
// - Resume test only after deepest sleep
// - Run or cyclic variant per target mode
// - Content select memory, logic or both
// - Test result readable afterwards
// - Execute zero skips, immediate release
// - Pin high: no test, wait timer
// - Pin low: test runs, release after
// - Stop bit gates peripheral clock
// - Stopped peripheral not reset, no access
// - Stop status clears once clock runs; in standby it follows the stop bit
// - Keep bit clocks peripheral in standby
module standby_resume_control
    import standby_resume_pkg::*;
#(
    parameter int unsigned WAIT_COUNT = WAIT_CYCLES
) (
    // Clock and reset
    input  wire logic                                clk_sys,
    input  wire logic                                arst_n,
    // Power state
    input  wire logic                                deep_sleep_entry,
    input  wire logic                                chip_standby,
    input  wire logic                                power_on_reset,
    // Buffer hold register
    input  wire logic [standby_resume_pkg::HOLD_GROUPS-1:0] hold_clear_we,
    output logic [standby_resume_pkg::HOLD_GROUPS-1:0]      buffer_hold_register,
    // Switchable pins
    input  wire logic [standby_resume_pkg::HOLD_GROUPS-1:0] cfg_out,
    input  wire logic [standby_resume_pkg::HOLD_GROUPS-1:0] cfg_oe,
    output logic [standby_resume_pkg::HOLD_GROUPS-1:0]      pin_out,
    output logic [standby_resume_pkg::HOLD_GROUPS-1:0]      pin_oe,
    // Resume self-test control
    input  wire logic                                deep_exit_reset,
    input  wire logic                                to_cyclic,
    input  wire logic                                run_execute_bit,
    input  wire logic                                cyclic_execute_bit,
    input  wire logic                                test_reset_pin,
    input  wire logic                                select_from_option,
    input  wire logic [1:0]                          option_byte3_sel,
    input  wire logic [1:0]                          resume_test_content_select,
    // Self-test engines
    input  wire logic                                test_done,
    input  wire logic                                test_pass,
    output logic                                     power_on_test_start,
    output logic                                     memory_test_start,
    output logic                                     logic_test_start,
    output logic                                     cpu_reset_release,
    output logic [1:0]                               self_test_result,
    // Module clock gating
    input  wire logic [standby_resume_pkg::CLK_GROUPS-1:0] module_clock_stop_bit,
    input  wire logic [standby_resume_pkg::CLK_GROUPS-1:0] standby_clock_keep_bit,
    output logic [standby_resume_pkg::CLK_GROUPS-1:0]      module_clk_en,
    output logic [standby_resume_pkg::CLK_GROUPS-1:0]      module_stop_status
);
    import standby_resume_pkg::*;

    // Logic leaves reset two edges after the pin rises
    logic rst_s1;
    logic rst_n;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    // Always-on groups keep state by nature, no hold logic
    logic [HOLD_GROUPS-1:0] next_hold;
    logic [HOLD_GROUPS-1:0] next_pin_out;
    logic [HOLD_GROUPS-1:0] next_pin_oe;

    always_comb begin
        next_hold    = buffer_hold_register & ~hold_clear_we;
        if (deep_sleep_entry) begin
            next_hold = {HOLD_GROUPS{1'b1}};
        end
        // Power-on wipes the hold, and the pins follow in the same edge
        if (power_on_reset) begin
            next_hold = HOLD_RESET;
        end
        for (int i = 0; i < HOLD_GROUPS; i++) begin
            next_pin_out[i] = pin_out[i];
            next_pin_oe[i]  = pin_oe[i];
            if (!next_hold[i]) begin
                next_pin_out[i] = cfg_out[i];
                next_pin_oe[i]  = cfg_oe[i];
            end
        end
    end

    // Hold state must survive the exit reset; power-on, arst_n and clear writes clear it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            buffer_hold_register <= HOLD_RESET;
            pin_out              <= HOLD_RESET;
            pin_oe               <= HOLD_RESET;
        end else begin
            buffer_hold_register <= next_hold;
            pin_out              <= next_pin_out;
            pin_oe               <= next_pin_oe;
        end
    end

    // Resume self-test sequencer
    seq_state_t       state;
    seq_state_t       next_state;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic             exec_bit;
    logic [1:0]       content;
    logic             next_power_on_test_start;
    logic             next_memory_test_start;
    logic             next_logic_test_start;
    logic             next_cpu_reset_release;
    logic [1:0]       next_result;

    always_comb begin
        exec_bit = to_cyclic ? cyclic_execute_bit : run_execute_bit;
        content  = select_from_option ? option_byte3_sel : resume_test_content_select;
        next_state               = state;
        next_count               = count;
        next_power_on_test_start = 1'b0;
        next_memory_test_start   = 1'b0;
        next_logic_test_start    = 1'b0;
        next_cpu_reset_release   = cpu_reset_release;
        next_result              = self_test_result;
        case (state)
            ST_IDLE: begin
                if (power_on_reset) begin
                    next_power_on_test_start = 1'b1;
                end
                if (deep_exit_reset) begin
                    next_cpu_reset_release = 1'b0;
                    next_state = ST_DECIDE;
                end
            end
            ST_DECIDE: begin
                // Pin and execute bit are read once, in this state
                // Count restarts here so a stale value never cuts a wait short
                next_count = '0;
                if (!exec_bit) begin
                    next_state = ST_DONE;
                end else if (test_reset_pin) begin
                    next_state = ST_WAIT;
                end else begin
                    next_memory_test_start = content[0];
                    next_logic_test_start  = content[1];
                    next_state = ST_TEST;
                end
            end
            ST_WAIT: begin
                // Timer runs although the test itself is masked
                next_count = count + CNT_W'(1);
                if (count >= CNT_W'(WAIT_COUNT - 1)) begin
                    next_state = ST_DONE;
                end
            end
            ST_TEST: begin
                if (test_done) begin
                    next_result = {1'b1, test_pass};
                    next_state  = ST_DONE;
                end
            end
            ST_DONE: begin
                // Single exit point, so every path releases the same way
                next_cpu_reset_release = 1'b1;
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state               <= ST_IDLE;
            count               <= '0;
            power_on_test_start <= 1'b0;
            memory_test_start   <= 1'b0;
            logic_test_start    <= 1'b0;
            cpu_reset_release   <= 1'b1;
            self_test_result    <= RESULT_RESET;
        end else begin
            state               <= next_state;
            count               <= next_count;
            power_on_test_start <= next_power_on_test_start;
            memory_test_start   <= next_memory_test_start;
            logic_test_start    <= next_logic_test_start;
            cpu_reset_release   <= next_cpu_reset_release;
            self_test_result    <= next_result;
        end
    end

    // Gated peripherals keep state; no reset is issued to them
    for (genvar g = 0; g < CLK_GROUPS; g++) begin : gen_gate
        clock_gate_slice u_gate (
            .clk_sys      (clk_sys),
            .rst_n        (rst_n),
            .stop_bit     (module_clock_stop_bit[g]),
            .keep_bit     (standby_clock_keep_bit[g]),
            .chip_standby (chip_standby),
            .clk_enable   (module_clk_en[g]),
            .stop_status  (module_stop_status[g])
        );
    end
endmodule

// *** verification/standby_resume_asserts.sv ***
`timescale 1ns/1ps
module standby_resume_asserts
    import standby_resume_pkg::*;
#(
    parameter int unsigned WAIT_COUNT = WAIT_CYCLES
) (
    // Clock, reset, power state
    input wire logic       clk_sys, arst_n, deep_sleep_entry, power_on_reset, chip_standby,
    // Resume sequence
    input wire logic       deep_exit_reset, to_cyclic, run_execute_bit, cyclic_execute_bit,
    input wire logic       test_reset_pin, select_from_option, test_pass,
    input wire logic       memory_test_start, logic_test_start, cpu_reset_release,
    input wire logic [1:0] option_byte3_sel, resume_test_content_select, self_test_result,
    // Pins and clock gates
    input wire logic [7:0] hold_clear_we, buffer_hold_register, cfg_out, pin_out,
    input wire logic [7:0] cfg_oe, pin_oe, module_clock_stop_bit, standby_clock_keep_bit,
    input wire logic [7:0] module_clk_en, module_stop_status
);
    default clocking @(posedge clk_sys); endclocking
    localparam int WAIT_MAX = WAIT_COUNT + 6;
    logic [2:0] up;
    logic       ready, exe, go;
    logic [1:0] sel;
    // Design runs from a synchronised reset copy, so hold off a few edges
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) up <= 3'h0;
        else if (!ready) up <= up + 3'h1;
    end
    assign ready = (up == 3'h5);
    assign exe   = to_cyclic ? cyclic_execute_bit : run_execute_bit;
    assign sel   = select_from_option ? option_byte3_sel : resume_test_content_select;
    assign go    = deep_exit_reset && cpu_reset_release;
    default disable iff (!arst_n || !ready);
    AST_HOLD_SET: assert property (
        deep_sleep_entry && !power_on_reset |=> &buffer_hold_register) else $error("hold not set");
    AST_HOLD_CLEAR: assert property (
        |hold_clear_we && !deep_sleep_entry |=> (buffer_hold_register & $past(hold_clear_we)) == 8'h00
    ) else $error("hold not cleared");
    AST_PIN_FROZEN: assert property (
        ((pin_out ^ $past(pin_out)) & buffer_hold_register) == 8'h00) else $error("held pin moved");
    AST_OE_FROZEN: assert property (
        ((pin_oe ^ $past(pin_oe)) & buffer_hold_register) == 8'h00) else $error("held enable moved");
    AST_PIN_FOLLOW: assert property (
        ((pin_out ^ $past(cfg_out)) & ~buffer_hold_register & ~$past(buffer_hold_register)) == 8'h00
    ) else $error("released pin not following");
    AST_OE_FOLLOW: assert property (
        ((pin_oe ^ $past(cfg_oe)) & ~buffer_hold_register & ~$past(buffer_hold_register)) == 8'h00
    ) else $error("released enable not following");
    AST_SKIP: assert property (
        go && !exe |=> !cpu_reset_release ##1 !cpu_reset_release ##1 cpu_reset_release
    ) else $error("skip release timing");
    AST_WAIT: assert property (
        go && exe && test_reset_pin |=> (!cpu_reset_release && !memory_test_start
        && !logic_test_start)[*5] ##[1:WAIT_MAX] cpu_reset_release) else $error("wait timing");
    AST_START: assert property (
        go && exe && !test_reset_pin |-> ##2 memory_test_start == sel[0] && logic_test_start == sel[1]
    ) else $error("test start mismatch");
    AST_START_IN_RESET: assert property (
        memory_test_start || logic_test_start |-> !cpu_reset_release) else $error("test outside reset");
    AST_RESULT: assert property (
        $rose(self_test_result[1]) |-> self_test_result[0] == $past(test_pass) && !cpu_reset_release
        ##[1:3] cpu_reset_release) else $error("result or release wrong");
    AST_CLK_EN: assert property (
        module_clk_en == (~$past(module_clock_stop_bit)
        & ($past(chip_standby) ? $past(standby_clock_keep_bit) : 8'hff))) else $error("clock enable");
    // Status stays up until the clock really runs again, except in standby where it follows the stop bit
    AST_STOP_STATUS: assert property (
        module_stop_status == ($past(chip_standby) ? $past(module_clock_stop_bit)
        : ($past(module_clock_stop_bit) | $past(module_clock_stop_bit, 2)
        | ({8{$past(chip_standby, 2)}} & ~$past(standby_clock_keep_bit, 2))))
    ) else $error("stop status");
endmodule
bind standby_resume_control standby_resume_asserts #(.WAIT_COUNT(WAIT_COUNT)) checker_i (
    .clk_sys, .arst_n, .deep_sleep_entry, .power_on_reset, .chip_standby, .deep_exit_reset,
    .to_cyclic, .run_execute_bit, .cyclic_execute_bit, .test_reset_pin, .select_from_option,
    .test_pass, .memory_test_start, .logic_test_start, .cpu_reset_release, .option_byte3_sel,
    .resume_test_content_select, .self_test_result, .hold_clear_we, .buffer_hold_register,
    .cfg_out, .pin_out, .cfg_oe, .pin_oe, .module_clock_stop_bit, .standby_clock_keep_bit,
    .module_clk_en, .module_stop_status);

// *** verification/tb_standby_resume_control.sv ***
`timescale 1ns/1ps
module tb_standby_resume_control;
    import standby_resume_pkg::*;
    localparam int unsigned W = 5;
    logic clk_sys = 0, arst_n = 0, deep_sleep_entry = 0, chip_standby = 0, power_on_reset = 0;
    logic deep_exit_reset = 0, to_cyclic = 0, run_execute_bit = 0, cyclic_execute_bit = 0;
    logic test_reset_pin = 0, select_from_option = 0, test_done = 0, test_pass = 0;
    logic power_on_test_start, memory_test_start, logic_test_start, cpu_reset_release;
    logic [1:0] option_byte3_sel = 0, resume_test_content_select = 0, self_test_result;
    logic [7:0] hold_clear_we = 0, cfg_out = 0, cfg_oe = 0, buffer_hold_register, pin_out, pin_oe;
    logic [7:0] module_clock_stop_bit = 0, standby_clock_keep_bit = 0, module_clk_en;
    logic [7:0] module_stop_status, c0, h, e, st, pe;
    int fails = 0, check_count = 0, n, eng = 0, mst, lst, pots, dn;
    standby_resume_control #(.WAIT_COUNT(W)) standby_resume_control_i (
        .clk_sys, .arst_n, .deep_sleep_entry, .chip_standby, .power_on_reset, .hold_clear_we,
        .buffer_hold_register, .cfg_out, .cfg_oe, .pin_out, .pin_oe, .deep_exit_reset,
        .to_cyclic, .run_execute_bit, .cyclic_execute_bit, .test_reset_pin, .select_from_option,
        .option_byte3_sel, .resume_test_content_select, .test_done, .test_pass,
        .power_on_test_start, .memory_test_start, .logic_test_start, .cpu_reset_release,
        .self_test_result, .module_clock_stop_bit, .standby_clock_keep_bit, .module_clk_en,
        .module_stop_status);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        if (fails == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Engine stand-in: answers each memory or logic start three cycles later; power_on_test_start gets no answer
    always @(posedge clk_sys) begin
        mst += (memory_test_start === 1'b1);
        lst += (logic_test_start === 1'b1);
        pots += (power_on_test_start === 1'b1);
        dn += (test_done === 1'b1);
        test_done <= (eng == 1);
        if (memory_test_start === 1'b1 || logic_test_start === 1'b1) eng <= 3;
        else if (eng != 0) eng <= eng - 1;
    end
    task automatic seq(input logic [3:0] k);
        logic [1:0] s;
        int c;
        s = 2'h1 + 2'($urandom % 3);
        @(posedge clk_sys);
        {to_cyclic, test_reset_pin, select_from_option} <= {k[3], k[1], k[0]};
        run_execute_bit <= k[3] ? 1'($urandom) : k[2];
        cyclic_execute_bit <= k[3] ? k[2] : 1'($urandom);
        option_byte3_sel <= k[0] ? s : 2'($urandom);
        resume_test_content_select <= k[0] ? 2'($urandom) : s;
        test_pass <= 1'($urandom);
        repeat (2) @(posedge clk_sys);
        mst = 0;
        lst = 0;
        dn = 0;
        deep_exit_reset <= 1'b1;
        @(posedge clk_sys) deep_exit_reset <= 1'b0;
        repeat (2) @(negedge clk_sys);
        for (c = 0; c < 60 && cpu_reset_release !== 1'b1; c++) @(negedge clk_sys);
        // Skip path: one settle cycle; wait path adds exactly the wait count
        if (!k[2]) chk(8'(c), 8'd1);
        else if (k[1]) chk(8'(c), 8'(W + 1));
        else begin
            chk({6'h0, lst[0], mst[0]}, {6'h0, s});
            chk({6'h0, self_test_result}, {6'h0, 1'b1, test_pass});
            chk(8'(dn), 8'h01);
        end
        if (!k[2] || k[1]) chk(8'(mst + lst), 8'h00);
    endtask
    initial begin
        clk_sys = 0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        print_verdict();
    end
    initial begin
        n = $urandom(32'h15eceb18);
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        c0 = 8'($urandom);
        cfg_out <= c0;
        cfg_oe <= c0;
        repeat (6) @(posedge clk_sys);
        chk({7'h0, cpu_reset_release}, 8'h01);
        chk(module_clk_en, 8'hff);
        // Clear request in the entry cycle must lose; held pins keep c0
        deep_sleep_entry <= 1'b1;
        hold_clear_we <= 8'hff;
        @(posedge clk_sys) {deep_sleep_entry, hold_clear_we} <= 9'h0;
        repeat (4) begin
            @(posedge clk_sys) cfg_out <= 8'($urandom);
            cfg_oe <= 8'($urandom);
            @(negedge clk_sys) chk(buffer_hold_register, 8'hff);
            chk(pin_out, c0);
            chk(pin_oe, c0);
        end
        h = 8'hff;
        @(posedge clk_sys) cfg_out <= ~c0;
        cfg_oe <= ~c0;
        for (n = 0; n < 8; n++) begin
            @(posedge clk_sys) hold_clear_we <= 8'h1 << ((n * 3) % 8);
            h[(n * 3) % 8] = 1'b0;
            @(posedge clk_sys) hold_clear_we <= 8'h0;
            @(negedge clk_sys) chk(buffer_hold_register, h);
            @(negedge clk_sys) chk(pin_out, (c0 & h) | (~c0 & ~h));
            chk(pin_oe, (c0 & h) | (~c0 & ~h));
        end
        @(posedge clk_sys) deep_sleep_entry <= 1'b1;
        @(posedge clk_sys) {deep_sleep_entry, power_on_reset} <= 2'b01;
        pots = 0;
        @(posedge clk_sys) power_on_reset <= 1'b0;
        repeat (3) @(negedge clk_sys);
        chk(buffer_hold_register, 8'h00);
        chk(8'(pots), 8'h01);
        for (n = 0; n < 16; n++) seq(4'(n));
        pe = 8'hff;
        repeat (200) begin
            @(posedge clk_sys);
            // Outside standby, status reads back set until the clock is supplied again
            st = chip_standby ? module_clock_stop_bit : module_clock_stop_bit | ~pe;
            e = ~module_clock_stop_bit & (chip_standby ? standby_clock_keep_bit : 8'hff);
            pe = e;
            module_clock_stop_bit <= 8'($urandom & $urandom);
            standby_clock_keep_bit <= 8'($urandom);
            chip_standby <= 1'($urandom);
            @(negedge clk_sys) chk(module_clk_en, e);
            chk(module_stop_status, st);
        end
        print_verdict();
    end
endmodule
